// ==== hw/ifc_pkg.sv ====
package ifc_pkg;
   // ======================================================================
   // register addresses
   localparam logic [7:0] ADDR_ISP_CONTROL   = 8'hBF;
   localparam logic [7:0] ADDR_OP_CONTROL    = 8'hC7;
   localparam logic [7:0] ADDR_TARGET_HIGH   = 8'hC5;
   localparam logic [7:0] ADDR_TARGET_LOW    = 8'hC4;
   localparam logic [7:0] ADDR_PROG_DATA     = 8'hC6;
   localparam logic [7:0] ADDR_WRITE_UNLOCK  = 8'hF6;
   localparam logic [7:0] ADDR_SECURITY_VIEW = 8'hC8;

   // ======================================================================
   // isp_control fields
   localparam int         CTL_SOFT_RESET_BIT  = 7;
   localparam int         CTL_RUN_BANK_BIT    = 5;
   localparam int         CTL_AUX_RAM_BIT     = 4;
   localparam int         CTL_MUST_ONE_BIT    = 3;
   localparam int         CTL_LOADER_ALT_BIT  = 1;
   localparam int         CTL_PROG_EN_BIT     = 0;
   localparam logic [7:0] CTL_WRITABLE_MASK   = 8'h93;
   localparam logic [7:0] CTL_RESET_VALUE     = 8'h00;

   // ======================================================================
   // flash_op_control fields
   localparam int         OPC_BANK_BIT = 6;
   localparam int         OPC_OE_BIT   = 5;
   localparam int         OPC_CE_BIT   = 4;
   localparam logic [3:0] OPC_ERASE    = 4'h2;
   localparam logic [3:0] OPC_PROGRAM  = 4'h1;
   localparam logic [3:0] OPC_READ     = 4'h0;
   localparam logic [7:0] OPC_RD_MASK  = 8'h7F;

   // ======================================================================
   // unlock keys
   localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h87;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h59;

   // ======================================================================
   // security register
   localparam logic [15:0] SEC_LOADER_ADDR   = 16'hFFFF;
   localparam int          SEC_LOCK_BIT      = 0;
   localparam int          SEC_TREAD_BIT     = 1;
   localparam int          SEC_ENCRYPT_BIT   = 2;
   localparam int          SEC_OSC_BIT       = 7;
   localparam logic [7:0]  SEC_ERASED        = 8'hFF;
   localparam logic [7:0]  FLASH_ERASED      = 8'hFF;
   localparam logic [7:0]  BLOCKED_READ      = 8'hFF;
   localparam logic [7:0]  DATA_ZERO         = 8'h00;

   // ======================================================================
   // boot strap capture
   localparam logic [2:0]  STRAP_SETTLE      = 3'h4;

   typedef enum logic [1:0] {
      IFC_UL_LOCKED,
      IFC_UL_GOT_FIRST,
      IFC_UL_OPEN
   } ifc_unlock_e;

   typedef enum logic [2:0] {
      IFC_OP_IDLE,
      IFC_OP_ERASE,
      IFC_OP_PROGRAM,
      IFC_OP_READ,
      IFC_OP_READ_WAIT
   } ifc_op_e;
endpackage

// ==== hw/ifc_flash_mem.sv ====
`timescale 1ns/1ps
module ifc_flash_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          sys_clk_i,
   input  wire logic          ce_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge sys_clk_i) begin
      if (ce_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (ce_i) begin
         rdata_o <= mem[addr_i];
      end
   end
endmodule

// ==== hw/ifc_top.sv ====
// What this block does
// - erase: code 0010, output enable high
// - program: code 0001 writes data to address
// - read: code 0000 returns byte to data
// - bank select picks loader or main bank
// - bits 7,1,0 set cause reset of all but security and strap state
// - bit 5 reads running bank, read-only
// - bit 4 switches auxiliary RAM on
// - control writes ignored unless unlocked
// - 0x83 restarts from main at once, no idle needed
// - no strap: boot from main bank
// - strap pins low: boot from loader bank
// - security bits cleared only by chip erase or power-on reset
// - security register at FFFF, programming mode
// - lock bit low blocks code reads
// - inhibit low: external table reads stay external
// - inhibit high: table reads unrestricted
// - encryption encodes port 0, erase clears
// - program enable plus idle enters loader
// - high/low registers form code address
// - wrong unlock write closes control access
`timescale 1ns/1ps
module ifc_top #(
   parameter int         MAIN_AW     = 16,
   parameter int         LOADER_AW   = 12,
   parameter logic [7:0] ENCRYPT_KEY = 8'hA5
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       cpu_idle_i,
   input  wire logic       wake_i,
   input  wire logic       strap_p27_i,
   input  wire logic       strap_p26_i,
   input  wire logic       strap_p43_i,
   input  wire logic       tread_from_ext_i,
   input  wire logic       tread_to_int_i,
   input  wire logic [7:0] p0_data_i,
   output logic            cpu_wake_o,
   output logic            sys_reset_o,
   output logic            busy_o,
   output logic            run_loader_o,
   output logic            isp_mode_o,
   output logic            aux_ram_en_o,
   output logic            tread_allow_o,
   output logic [7:0]      p0_data_o,
   output logic            osc_half_gain_o
);
   // ======================================================================
   // state
   ifc_pkg::ifc_unlock_e ul_reg;
   ifc_pkg::ifc_op_e     op_reg;
   logic [7:0]           ctl_reg;
   logic [7:0]           opc_reg;
   logic [7:0]           addr_hi_reg;
   logic [7:0]           addr_lo_reg;
   logic [7:0]           data_reg;
   logic [7:0]           sec_reg;
   logic                 sw_rst_reg;
   logic                 run_loader_reg;
   logic                 wake_pend_reg;
   logic [15:0]          cnt_reg;
   logic                 op_bank_reg;
   logic                 op_sec_reg;
   logic [2:0]           sync_reg [0:2];
   logic [2:0]           boot_cnt_reg;
   logic                 any_rst;
   logic [15:0]          target;
   logic                 wr_ctl;
   logic                 wr_opc;
   logic                 mem_we;
   logic [15:0]          mem_addr;
   logic [7:0]           mem_wdata;
   logic [7:0]           main_rdata;
   logic [7:0]           ldr_rdata;
   logic                 strap_reboot;
   logic                 prog_mode;

   assign any_rst   = rst_i | sw_rst_reg;
   assign target    = {addr_hi_reg, addr_lo_reg};
   assign wr_ctl    = wr_i && (addr_i == ifc_pkg::ADDR_ISP_CONTROL);
   assign wr_opc    = wr_i && (addr_i == ifc_pkg::ADDR_OP_CONTROL);
   assign prog_mode = run_loader_reg | ctl_reg[ifc_pkg::CTL_PROG_EN_BIT];

   // decode an operation byte; idle means not a valid request
   function automatic ifc_pkg::ifc_op_e op_decode(input logic [7:0] v);
      ifc_pkg::ifc_op_e r;
      r = ifc_pkg::IFC_OP_IDLE;
      if (!v[ifc_pkg::OPC_CE_BIT]) begin
         if (v[3:0] == ifc_pkg::OPC_ERASE && v[ifc_pkg::OPC_OE_BIT]) begin
            r = ifc_pkg::IFC_OP_ERASE;
         end else if (v[3:0] == ifc_pkg::OPC_PROGRAM && v[ifc_pkg::OPC_OE_BIT]) begin
            r = ifc_pkg::IFC_OP_PROGRAM;
         end else if (v[3:0] == ifc_pkg::OPC_READ && !v[ifc_pkg::OPC_OE_BIT]) begin
            r = ifc_pkg::IFC_OP_READ;
         end
      end
      return r;
   endfunction

   // ======================================================================
   // unlock sequencer for the control register
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         ul_reg <= ifc_pkg::IFC_UL_LOCKED;
      end else if (ce_i && wr_i && addr_i == ifc_pkg::ADDR_WRITE_UNLOCK) begin
         case (ul_reg)
            ifc_pkg::IFC_UL_LOCKED: begin
               ul_reg <= (wdata_i == ifc_pkg::UNLOCK_KEY_FIRST) ? ifc_pkg::IFC_UL_GOT_FIRST
                                                                 : ifc_pkg::IFC_UL_LOCKED;
            end
            ifc_pkg::IFC_UL_GOT_FIRST: begin
               ul_reg <= (wdata_i == ifc_pkg::UNLOCK_KEY_SECOND) ? ifc_pkg::IFC_UL_OPEN
                                                                  : ifc_pkg::IFC_UL_LOCKED;
            end
            default: begin
               ul_reg <= ifc_pkg::IFC_UL_LOCKED;
            end
         endcase
      end
   end

   // ======================================================================
   // isp_control and soft reset
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         ctl_reg <= ifc_pkg::CTL_RESET_VALUE;
      end else if (ce_i && wr_ctl && ul_reg == ifc_pkg::IFC_UL_OPEN) begin
         ctl_reg <= wdata_i & ifc_pkg::CTL_WRITABLE_MASK;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         sw_rst_reg <= 1'b0;
      end else if (ce_i) begin
         sw_rst_reg <= ctl_reg[ifc_pkg::CTL_SOFT_RESET_BIT] &
                       ctl_reg[ifc_pkg::CTL_LOADER_ALT_BIT] &
                       ctl_reg[ifc_pkg::CTL_PROG_EN_BIT];
      end
   end

   // ======================================================================
   // strap synchronisers and boot bank
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 3; i++) begin
            sync_reg[i] <= 3'h7;
         end
      end else if (ce_i) begin
         sync_reg[0] <= {strap_p43_i, strap_p27_i, strap_p26_i};
         sync_reg[1] <= sync_reg[0];
         sync_reg[2] <= sync_reg[1];
      end
   end

   assign strap_reboot = (!sync_reg[2][2]) || (!sync_reg[2][1] && !sync_reg[2][0]);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         boot_cnt_reg <= 3'h0;
      end else if (ce_i && boot_cnt_reg != ifc_pkg::STRAP_SETTLE && sync_reg[1] == sync_reg[2]) begin
         boot_cnt_reg <= boot_cnt_reg + 3'h1;
      end
   end

   // soft reset returns to main; straps are sampled only after power-on reset
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         run_loader_reg <= 1'b0;
      end else if (ce_i) begin
         if (boot_cnt_reg == ifc_pkg::STRAP_SETTLE - 3'h1 && sync_reg[1] == sync_reg[2]) begin
            run_loader_reg <= strap_reboot;
         end else if (wake_pend_reg && op_reg == ifc_pkg::IFC_OP_IDLE &&
                      ctl_reg[ifc_pkg::CTL_PROG_EN_BIT]) begin
            run_loader_reg <= 1'b1;
         end
      end
   end

   // ======================================================================
   // wake from idle, held back while an operation runs
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         wake_pend_reg <= 1'b0;
         cpu_wake_o    <= 1'b0;
      end else if (ce_i) begin
         cpu_wake_o <= wake_pend_reg && op_reg == ifc_pkg::IFC_OP_IDLE;
         if (wake_pend_reg && op_reg == ifc_pkg::IFC_OP_IDLE) begin
            wake_pend_reg <= 1'b0;
         end else if (wake_i && cpu_idle_i) begin
            wake_pend_reg <= 1'b1;
         end
      end
   end

   // ======================================================================
   // address, data and op registers
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         addr_hi_reg <= ifc_pkg::DATA_ZERO;
         addr_lo_reg <= ifc_pkg::DATA_ZERO;
         opc_reg     <= ifc_pkg::DATA_ZERO;
      end else if (ce_i) begin
         if (wr_i && addr_i == ifc_pkg::ADDR_TARGET_HIGH) begin
            addr_hi_reg <= wdata_i;
         end
         if (wr_i && addr_i == ifc_pkg::ADDR_TARGET_LOW) begin
            addr_lo_reg <= wdata_i;
         end
         if (wr_opc && op_reg == ifc_pkg::IFC_OP_IDLE) begin
            opc_reg <= wdata_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         data_reg <= ifc_pkg::DATA_ZERO;
      end else if (ce_i) begin
         if (op_reg == ifc_pkg::IFC_OP_READ_WAIT) begin
            if (!sec_reg[ifc_pkg::SEC_LOCK_BIT]) begin
               data_reg <= ifc_pkg::BLOCKED_READ;
            end else if (op_sec_reg) begin
               data_reg <= sec_reg;
            end else begin
               data_reg <= op_bank_reg ? ldr_rdata : main_rdata;
            end
         end else if (wr_i && addr_i == ifc_pkg::ADDR_PROG_DATA) begin
            data_reg <= wdata_i;
         end
      end
   end

   // ======================================================================
   // operation sequencer
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         op_reg      <= ifc_pkg::IFC_OP_IDLE;
         cnt_reg     <= 16'h0000;
         op_bank_reg <= 1'b0;
         op_sec_reg  <= 1'b0;
      end else if (ce_i) begin
         case (op_reg)
            ifc_pkg::IFC_OP_IDLE: begin
               if (wr_opc) begin
                  op_reg      <= op_decode(wdata_i);
                  op_bank_reg <= wdata_i[ifc_pkg::OPC_BANK_BIT];
                  op_sec_reg  <= wdata_i[ifc_pkg::OPC_BANK_BIT] && prog_mode &&
                                 target == ifc_pkg::SEC_LOADER_ADDR;
                  cnt_reg     <= 16'h0000;
               end
            end
            ifc_pkg::IFC_OP_ERASE: begin
               // sweep every word of the chosen bank; address registers unused
               if (cnt_reg == (op_bank_reg ? 16'((1 << LOADER_AW) - 1) : 16'((1 << MAIN_AW) - 1))) begin
                  op_reg <= ifc_pkg::IFC_OP_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            ifc_pkg::IFC_OP_PROGRAM: begin
               op_reg <= ifc_pkg::IFC_OP_IDLE;
            end
            ifc_pkg::IFC_OP_READ: begin
               op_reg <= ifc_pkg::IFC_OP_READ_WAIT;
            end
            default: begin
               op_reg <= ifc_pkg::IFC_OP_IDLE;
            end
         endcase
      end
   end

   // ======================================================================
   // security register, programmed bits only fall
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sec_reg <= ifc_pkg::SEC_ERASED;
      end else if (ce_i) begin
         if (op_reg == ifc_pkg::IFC_OP_ERASE && !op_bank_reg) begin
            sec_reg <= ifc_pkg::SEC_ERASED;
         end else if (op_reg == ifc_pkg::IFC_OP_PROGRAM && op_sec_reg) begin
            sec_reg <= sec_reg & data_reg;
         end
      end
   end

   // ======================================================================
   // flash banks
   assign mem_we    = (op_reg == ifc_pkg::IFC_OP_ERASE) ||
                      (op_reg == ifc_pkg::IFC_OP_PROGRAM && !op_sec_reg);
   assign mem_addr  = (op_reg == ifc_pkg::IFC_OP_ERASE) ? cnt_reg : target;
   assign mem_wdata = (op_reg == ifc_pkg::IFC_OP_ERASE) ? ifc_pkg::FLASH_ERASED : data_reg;

   ifc_flash_mem #(.AW(MAIN_AW), .DW(8)) u_main (
      .sys_clk_i (sys_clk_i),
      .ce_i      (ce_i),
      .we_i      (mem_we && !op_bank_reg),
      .addr_i    (mem_addr[MAIN_AW-1:0]),
      .wdata_i   (mem_wdata),
      .rdata_o   (main_rdata)
   );

   ifc_flash_mem #(.AW(LOADER_AW), .DW(8)) u_loader (
      .sys_clk_i (sys_clk_i),
      .ce_i      (ce_i),
      .we_i      (mem_we && op_bank_reg),
      .addr_i    (mem_addr[LOADER_AW-1:0]),
      .wdata_i   (mem_wdata),
      .rdata_o   (ldr_rdata)
   );

   // ======================================================================
   // register reads
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         rdata_o <= ifc_pkg::DATA_ZERO;
      end else if (ce_i) begin
         rdata_o <= ifc_pkg::DATA_ZERO;
         if (rd_i) begin
            case (addr_i)
               ifc_pkg::ADDR_ISP_CONTROL: begin
                  rdata_o <= ctl_reg;
                  rdata_o[ifc_pkg::CTL_RUN_BANK_BIT] <= run_loader_reg;
                  rdata_o[ifc_pkg::CTL_MUST_ONE_BIT] <= 1'b1;
               end
               ifc_pkg::ADDR_OP_CONTROL:    rdata_o <= opc_reg & ifc_pkg::OPC_RD_MASK;
               ifc_pkg::ADDR_TARGET_HIGH:   rdata_o <= addr_hi_reg;
               ifc_pkg::ADDR_TARGET_LOW:    rdata_o <= addr_lo_reg;
               ifc_pkg::ADDR_PROG_DATA:     rdata_o <= data_reg;
               ifc_pkg::ADDR_SECURITY_VIEW: begin
                  rdata_o <= (sec_reg[ifc_pkg::SEC_LOCK_BIT] && prog_mode) ? sec_reg
                                                                         : ifc_pkg::BLOCKED_READ;
               end
               default:                     rdata_o <= ifc_pkg::DATA_ZERO;
            endcase
         end
      end
   end

   // ======================================================================
   // status and security-driven outputs
   always_ff @(posedge sys_clk_i) begin
      if (any_rst) begin
         sys_reset_o     <= 1'b0;
         busy_o          <= 1'b0;
         run_loader_o    <= 1'b0;
         isp_mode_o      <= 1'b0;
         aux_ram_en_o    <= 1'b0;
         tread_allow_o   <= 1'b0;
         p0_data_o       <= ifc_pkg::DATA_ZERO;
         osc_half_gain_o <= 1'b0;
      end else if (ce_i) begin
         sys_reset_o     <= ctl_reg[ifc_pkg::CTL_SOFT_RESET_BIT] &
                            ctl_reg[ifc_pkg::CTL_LOADER_ALT_BIT] &
                            ctl_reg[ifc_pkg::CTL_PROG_EN_BIT];
         busy_o          <= (op_reg != ifc_pkg::IFC_OP_IDLE) || wr_opc;
         run_loader_o    <= run_loader_reg;
         isp_mode_o      <= prog_mode;
         aux_ram_en_o    <= ctl_reg[ifc_pkg::CTL_AUX_RAM_BIT];
         tread_allow_o   <= sec_reg[ifc_pkg::SEC_TREAD_BIT] ||
                            !tread_from_ext_i || !tread_to_int_i;
         p0_data_o       <= sec_reg[ifc_pkg::SEC_ENCRYPT_BIT] ? p0_data_i
                                                               : p0_data_i ^ ENCRYPT_KEY;
         osc_half_gain_o <= !sec_reg[ifc_pkg::SEC_OSC_BIT];
      end
   end

   // ======================================================================
   // assertions
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_ctl_write_gate: assert property (ce_i && wr_ctl && ul_reg != ifc_pkg::IFC_UL_OPEN && !sw_rst_reg
      |=> ctl_reg == $past(ctl_reg)) else $error("locked control register changed");
   a_soft_reset_fire: assert property (ce_i && !sw_rst_reg && ctl_reg[7] && ctl_reg[1] && ctl_reg[0]
      |=> sw_rst_reg ##1 !run_loader_reg && ctl_reg == ifc_pkg::CTL_RESET_VALUE)
      else $error("soft reset did not clear state");
   a_bad_key_close: assert property (ce_i && !sw_rst_reg && wr_i && addr_i == ifc_pkg::ADDR_WRITE_UNLOCK &&
      ul_reg == ifc_pkg::IFC_UL_GOT_FIRST && wdata_i != ifc_pkg::UNLOCK_KEY_SECOND
      |=> ul_reg == ifc_pkg::IFC_UL_LOCKED) else $error("wrong key left access open");
   a_run_bank_read: assert property (ce_i && !sw_rst_reg && rd_i && addr_i == ifc_pkg::ADDR_ISP_CONTROL
      |=> rdata_o[5] == $past(run_loader_reg) && rdata_o[3]) else $error("running bank flag wrong");
   a_wake_after_op: assert property (cpu_wake_o |-> $past(op_reg) == ifc_pkg::IFC_OP_IDLE)
      else $error("wake released during operation");
   a_sec_no_rise: assert property (ce_i && !(op_reg == ifc_pkg::IFC_OP_ERASE && !op_bank_reg)
      |=> (sec_reg & ~$past(sec_reg)) == 8'h00) else $error("security bit returned high");
   a_lock_blocks: assert property (ce_i && !sw_rst_reg && op_reg == ifc_pkg::IFC_OP_READ_WAIT &&
      !sec_reg[0] |=> data_reg == ifc_pkg::BLOCKED_READ) else $error("locked read leaked data");
   a_program_once: assert property (ce_i && !sw_rst_reg && op_reg == ifc_pkg::IFC_OP_PROGRAM
      |=> op_reg == ifc_pkg::IFC_OP_IDLE) else $error("program did not finish");
   a_read_two_step: assert property (ce_i && !sw_rst_reg && op_reg == ifc_pkg::IFC_OP_IDLE && wr_opc &&
      wdata_i[5:0] == 6'h00 ##1 ce_i && !sw_rst_reg |=> op_reg == ifc_pkg::IFC_OP_READ_WAIT)
      else $error("read sequence wrong");
   a_osc_gain: assert property ($past(ce_i) && !$past(sw_rst_reg)
      |-> osc_half_gain_o == !$past(sec_reg[7])) else $error("oscillator gain wrong");

   c_erase_done: cover property (op_reg == ifc_pkg::IFC_OP_ERASE ##1 op_reg == ifc_pkg::IFC_OP_IDLE);
   c_read_done:  cover property (op_reg == ifc_pkg::IFC_OP_READ_WAIT);
   c_soft_reset: cover property (sys_reset_o);
   c_enter_isp:  cover property (cpu_wake_o && run_loader_reg);
endmodule

// ==== dv/ifc_wake_timer.sv ====
`timescale 1ns/1ps
// ==========================================
// idle timer standing in for the cpu side
module ifc_wake_timer #(
   parameter int DELAY = 6
) (
   input  wire logic sys_clk_i,
   input  wire logic idle_i,
   output logic      wake_o
);
   int cnt = 0;
   initial wake_o = 1'b0;
   // one wake pulse a fixed time after idle is entered
   always @(posedge sys_clk_i) begin
      cnt    <= idle_i ? cnt + 1 : 0;
      wake_o <= idle_i && (cnt == DELAY);
   end
endmodule

// ==== dv/isp_flash_control_and_boot_tb.sv ====
`timescale 1ns/1ps
// ==========================================
// bench
module isp_flash_control_and_boot_tb;
   localparam logic [7:0] KEY = 8'hA5;
   logic       clk, rst, wr, rd, idle, wake, p43, fe, ti, pend, ce, ispm;
   logic [7:0] a, wd, rdat, p0, p0o, d;
   logic       cpu_wake, sreset, busy, runl, auxo, tallow, half;
   logic [7:0] exp_q[$];
   int         err_count, n_tests, seed, b;
   ifc_top #(.MAIN_AW(4), .LOADER_AW(4), .ENCRYPT_KEY(KEY)) u_dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce),
      .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .cpu_idle_i(idle), .wake_i(wake),
      .strap_p27_i(1'b1), .strap_p26_i(1'b1), .strap_p43_i(p43), .tread_from_ext_i(fe), .tread_to_int_i(ti),
      .p0_data_i(p0), .cpu_wake_o(cpu_wake), .sys_reset_o(sreset), .busy_o(busy), .run_loader_o(runl),
      .isp_mode_o(ispm), .aux_ram_en_o(auxo), .tread_allow_o(tallow), .p0_data_o(p0o), .osc_half_gain_o(half));
   ifc_wake_timer u_tmr (.sys_clk_i(clk), .idle_i(idle), .wake_o(wake));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic w(input logic [7:0] ad, input logic [7:0] v);
      @(posedge clk);
      a <= ad; wd <= v; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic r(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clk);
      a <= ad; rd <= 1'b1; exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic waitfor(input int k);
      for (int i = 0; i < 300; i++) begin
         @(posedge clk); #1;
         if (k == 0 ? busy === 1'b0 : k == 1 ? cpu_wake === 1'b1 : sreset === 1'b1) return;
      end
      err_count++;
      stop_test;
   endtask
   task automatic op(input logic [7:0] c);
      w(8'hC7, c);
      waitfor(0);
   endtask
   task automatic unl;
      w(8'hF6, 8'h87);
      w(8'hF6, 8'h59);
   endtask
   task automatic reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   always @(posedge clk) pend <= rd;
   always @(negedge clk) if (pend) chk("rdata", rdat, exp_q.pop_front());
   initial begin
      {rst, wr, rd, idle, fe, ti, a, wd, p0, pend, err_count, n_tests} = '0;
      p43 = 1'b1; seed = 49; ce = 1'b1;
      reset;
      r(8'hBF, 8'h08);
      chk("isp", 8'(ispm), 8'h00);
      // clock enable low must freeze the data register
      ce <= 1'b0; w(8'hC6, 8'h5A); ce <= 1'b1; r(8'hC6, 8'h00);
      w(8'hBF, 8'h10); r(8'hBF, 8'h08);
      unl; w(8'hBF, 8'h10); w(8'hF6, 8'h00); r(8'hBF, 8'h18);
      chk("aux", 8'(auxo), 8'h01);
      w(8'hBF, 8'h00); r(8'hBF, 8'h18);
      for (b = 0; b < 2; b++) begin
         op({1'b0, b[0], 6'h22});
         d = $random(seed);
         w(8'hC5, $random(seed)); w(8'hC4, $random(seed)); w(8'hC6, d);
         op({1'b0, b[0], 6'h21}); w(8'hC6, 8'h00);
         op({1'b0, b[0], 6'h00}); r(8'hC6, d);
      end
      p43 <= 1'b0; reset; p43 <= 1'b1;
      chk("loader", 8'(runl), 8'h01); r(8'hBF, 8'h28);
      chk("isp2", 8'(ispm), 8'h01);
      w(8'hC5, 8'hFF); w(8'hC4, 8'hFF); w(8'hC6, 8'h78); op(8'h61);
      p0 <= $random(seed); fe <= 1'b1; ti <= 1'b1;
      repeat (3) @(posedge clk); #1;
      chk("half", 8'(half), 8'h01); chk("p0", p0o, p0 ^ KEY);
      chk("tread", 8'(tallow), 8'h00);
      op(8'h40); r(8'hC6, 8'hFF);
      op(8'h22); repeat (3) @(posedge clk); #1;
      chk("half2", 8'(half), 8'h00); chk("tread2", 8'(tallow), 8'h01);
      unl; w(8'hBF, 8'h83); waitfor(2);
      repeat (3) @(posedge clk);
      r(8'hBF, 8'h08);
      unl; w(8'hBF, 8'h01); idle <= 1'b1; waitfor(1);
      idle <= 1'b0; @(posedge clk); #1;
      chk("wake", 8'(runl), 8'h01);
      repeat (3) @(posedge clk);
      stop_test;
   end
endmodule
